// ==== wit_pkg.sv ====
package wit_pkg;
    // Read and write addresses of the three registers
    localparam logic [15:0] ADDR_CTRL_RD = 16'hFFBC;
    localparam logic [15:0] ADDR_COUNT_RD = 16'hFFBD;
    localparam logic [15:0] ADDR_RSTCTRL_RD = 16'hFFBF;
    localparam logic [15:0] ADDR_CNTCTRL_WR = 16'hFFBC;
    localparam logic [15:0] ADDR_RSTCTRL_WR = 16'hFFBE;

    // Upper-byte keys of the protected word writes
    localparam logic [7:0] KEY_CTRL = 8'hA5;
    localparam logic [7:0] KEY_COUNT = 8'h5A;
    localparam logic [7:0] KEY_CHIP_RESET_ENABLE = 8'h5A;
    localparam logic [7:0] KEY_WOVF = 8'hA5;

    // Control/status field positions and reset value
    localparam int CS_FLAG_BIT = 7;
    localparam int CS_MODE_BIT = 6;
    localparam int CS_EN_BIT = 5;
    localparam int CS_CKS_MSB = 2;
    localparam logic [7:0] CS_FIXED = 8'h18;
    localparam logic [2:0] CKS_RESET = 3'h0;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COUNT_TOP = 8'hFF;

    // Reset control field positions
    localparam int RC_FLAG_BIT = 7;
    localparam int RC_CHIP_RESET_ENABLE_BIT = 6;
    localparam int RC_SPARE_BIT = 5;
    localparam logic [4:0] RC_FIXED = 5'h1F;

    // Prescaler taps: tick when the low bits are all ones
    localparam int PRE_W = 17;
    localparam logic [16:0] DIV_MASK [8] = '{17'h00001, 17'h0003F, 17'h0007F, 17'h001FF,
                                            17'h007FF, 17'h01FFF, 17'h07FFF, 17'h1FFFF};

    // Pulse timing, one state per clock
    localparam int CLK_PERIOD_NS = 100;
    localparam int STATE_NS = 100;
    localparam int OVF_CHIP_RESET_ENABLE_STATES = 132;
    localparam int OVF_NORST_STATES = 130;
    localparam int CHIP_RST_STATES = 518;
    localparam int PULSE_W = 10;
    localparam logic [9:0] OVF_CHIP_RESET_ENABLE_CYC = 10'((OVF_CHIP_RESET_ENABLE_STATES * STATE_NS) / CLK_PERIOD_NS);
    localparam logic [9:0] OVF_NORST_CYC = 10'((OVF_NORST_STATES * STATE_NS) / CLK_PERIOD_NS);
    localparam logic [9:0] CHIP_RST_CYC = 10'((CHIP_RST_STATES * STATE_NS) / CLK_PERIOD_NS);
endpackage

// ==== wit_tick_if.sv ====
`timescale 1ns/1ps
interface wit_tick_if;
    logic enable;
    logic [2:0] sel;
    logic tick;
    modport timer(output enable, output sel, input tick);
    modport divider(input enable, input sel, output tick);
endinterface

// ==== wit_prescaler.sv ====
`timescale 1ns/1ps
module wit_prescaler (
    input wire logic clk,
    input wire logic resetn,
    wit_tick_if.divider tk
);
    logic [16:0] div_r, div_nxt;
    logic tick_r, tick_nxt;

    // Divider restarts from zero on enable, so the first tick is a full period away
    always_comb begin
        div_nxt = tk.enable ? div_r + 17'h00001 : 17'h00000;
        tick_nxt = tk.enable && ((div_r & wit_pkg::DIV_MASK[tk.sel]) == wit_pkg::DIV_MASK[tk.sel]);
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            div_r <= 17'h00000;
            tick_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tk.tick = tick_r;
endmodule

// ==== wit_pulse.sv ====
`timescale 1ns/1ps
module wit_pulse (
    input wire logic clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic [9:0] len,
    output logic active,
    output logic activeN
);
    logic [9:0] cnt_r, cnt_nxt;
    logic act_r, act_nxt;
    logic actN_r;

    // A new start reloads the length, stretching a running pulse
    always_comb begin
        cnt_nxt = start ? len : ((cnt_r != 10'h000) ? cnt_r - 10'h001 : 10'h000);
        act_nxt = (cnt_nxt != 10'h000);
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cnt_r <= 10'h000;
            act_r <= 1'b0;
            actN_r <= 1'b1;
        end else begin
            cnt_r <= cnt_nxt;
            act_r <= act_nxt;
            actN_r <= ~act_nxt;
        end
    end

    // Both polarities come from their own flops, so the pin has no gate after the register
    assign active = act_r;
    assign activeN = actN_r;
endmodule

// ==== wit_guard_timer.sv ====
`timescale 1ns/1ps
module wit_guard_timer (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] busAddr,
    input wire logic busRead,
    input wire logic busWrite,
    input wire logic busWord,
    input wire logic [15:0] busWdata,
    output logic [7:0] busRdata,
    output logic overflowOutN,
    output logic intervalIrq,
    output logic chipResetOut
);
    logic [7:0] count_r, count_nxt;
    logic flag_r, flag_nxt;
    logic flagArm_r, flagArm_nxt;
    logic mode_r, mode_nxt;
    logic en_r, en_nxt;
    logic [2:0] cks_r, cks_nxt;
    logic wovf_r, wovf_nxt;
    logic wovfArm_r, wovfArm_nxt;
    logic chip_reset_enable_r, chip_reset_enable_nxt;
    logic spare_r, spare_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic wrCntCtrl, wrCount, wrCtrl, wrRc, wrRste, wrWovf;
    logic rdCtrl, rdCount, rdRc;
    logic ovf, wdOvf, itOvf;
    logic [9:0] ovfLen;
    logic ovfActive;

    wit_tick_if tickBus();

    assign tickBus.enable = en_r;
    assign tickBus.sel = cks_r;

    wit_prescaler u_prescaler (
        .clk(clk),
        .resetn(resetn),
        .tk(tickBus.divider)
    );

    // Protected writes: word access, right address, right key in the upper byte
    always_comb begin
        wrCntCtrl = busWrite && busWord && (busAddr == wit_pkg::ADDR_CNTCTRL_WR);
        wrCount = wrCntCtrl && (busWdata[15:8] == wit_pkg::KEY_COUNT);
        wrCtrl = wrCntCtrl && (busWdata[15:8] == wit_pkg::KEY_CTRL);
        wrRc = busWrite && busWord && (busAddr == wit_pkg::ADDR_RSTCTRL_WR);
        wrRste = wrRc && (busWdata[15:8] == wit_pkg::KEY_CHIP_RESET_ENABLE);
        wrWovf = wrRc && (busWdata[15:8] == wit_pkg::KEY_WOVF) && !busWdata[7];
        rdCtrl = busRead && (busAddr == wit_pkg::ADDR_CTRL_RD);
        rdCount = busRead && (busAddr == wit_pkg::ADDR_COUNT_RD);
        rdRc = busRead && (busAddr == wit_pkg::ADDR_RSTCTRL_RD);
    end

    // Overflow on the tick that wraps FF; a same-cycle count write wins and suppresses it
    always_comb begin
        ovf = en_r && tickBus.tick && (count_r == wit_pkg::COUNT_TOP) && !wrCount;
        wdOvf = ovf && mode_r;
        itOvf = ovf && !mode_r;
    end

    // Counter and control/status next values
    always_comb begin
        count_nxt = count_r;
        flag_nxt = flag_r;
        flagArm_nxt = flagArm_r;
        mode_nxt = mode_r;
        en_nxt = en_r;
        cks_nxt = cks_r;
        if (!en_r) begin
            count_nxt = wit_pkg::COUNT_RESET;
        end else if (wrCount) begin
            count_nxt = busWdata[7:0];
        end else if (tickBus.tick) begin
            count_nxt = count_r + 8'h01;
        end
        if (rdCtrl && flag_r) begin
            flagArm_nxt = 1'b1;
        end
        if (wrCtrl) begin
            mode_nxt = busWdata[wit_pkg::CS_MODE_BIT];
            en_nxt = busWdata[wit_pkg::CS_EN_BIT];
            cks_nxt = busWdata[wit_pkg::CS_CKS_MSB:0];
            flagArm_nxt = 1'b0;
            if (flagArm_r && !busWdata[wit_pkg::CS_FLAG_BIT]) begin
                flag_nxt = 1'b0;
            end
        end
        // Set wins over a clear in the same cycle
        if (itOvf) begin
            flag_nxt = 1'b1;
        end
        // Watchdog overflow resets the counter side whichever reset choice is made
        if (wdOvf) begin
            count_nxt = wit_pkg::COUNT_RESET;
            flag_nxt = 1'b0;
            flagArm_nxt = 1'b0;
            mode_nxt = 1'b0;
            en_nxt = 1'b0;
            cks_nxt = wit_pkg::CKS_RESET;
        end
    end

    // Reset control: survives the internal reset, only resetn clears it
    always_comb begin
        wovf_nxt = wovf_r;
        wovfArm_nxt = wovfArm_r;
        chip_reset_enable_nxt = chip_reset_enable_r;
        spare_nxt = spare_r;
        if (rdRc && wovf_r) begin
            wovfArm_nxt = 1'b1;
        end
        if (wrWovf && wovfArm_r) begin
            wovf_nxt = 1'b0;
            wovfArm_nxt = 1'b0;
        end
        if (wrRste) begin
            chip_reset_enable_nxt = busWdata[wit_pkg::RC_CHIP_RESET_ENABLE_BIT];
            spare_nxt = busWdata[wit_pkg::RC_SPARE_BIT];
        end
        if (wdOvf) begin
            wovf_nxt = 1'b1;
        end
    end

    // Read data appears the cycle after the read strobe, zero otherwise
    always_comb begin
        rdata_nxt = 8'h00;
        if (rdCtrl) begin
            rdata_nxt = {flag_r, mode_r, en_r, 2'b00, cks_r} | wit_pkg::CS_FIXED;
        end else if (rdCount) begin
            rdata_nxt = count_r;
        end else if (rdRc) begin
            rdata_nxt = {wovf_r, chip_reset_enable_r, spare_r, wit_pkg::RC_FIXED};
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            count_r <= 8'h00;
            flag_r <= 1'b0;
            flagArm_r <= 1'b0;
            mode_r <= 1'b0;
            en_r <= 1'b0;
            cks_r <= 3'h0;
            wovf_r <= 1'b0;
            wovfArm_r <= 1'b0;
            chip_reset_enable_r <= 1'b0;
            spare_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            count_r <= count_nxt;
            flag_r <= flag_nxt;
            flagArm_r <= flagArm_nxt;
            mode_r <= mode_nxt;
            en_r <= en_nxt;
            cks_r <= cks_nxt;
            wovf_r <= wovf_nxt;
            wovfArm_r <= wovfArm_nxt;
            chip_reset_enable_r <= chip_reset_enable_nxt;
            spare_r <= spare_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Overflow pin length follows the reset choice at the moment of overflow
    assign ovfLen = chip_reset_enable_r ? wit_pkg::OVF_CHIP_RESET_ENABLE_CYC : wit_pkg::OVF_NORST_CYC;

    wit_pulse u_ovf_pulse (
        .clk(clk),
        .resetn(resetn),
        .start(wdOvf),
        .len(ovfLen),
        .active(ovfActive),
        .activeN(overflowOutN)
    );

    wit_pulse u_chip_pulse (
        .clk(clk),
        .resetn(resetn),
        .start(wdOvf && chip_reset_enable_r),
        .len(wit_pkg::CHIP_RST_CYC),
        .active(chipResetOut),
        .activeN()
    );

    // Request stands as long as the flag, so the handler must clear it
    assign intervalIrq = flag_r;
    assign busRdata = rdata_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    count_hold_a: assert property (!en_r |=> count_r == 8'h00) else $error("count not zero while disabled");
    count_step_a: assert property (en_r && tickBus.tick && !wrCount && !wdOvf |=> count_r == $past(count_r) + 8'h01)
        else $error("count did not step on tick");
    mode_read_a: assert property (rdCtrl |=> busRdata[6] == $past(mode_r)) else $error("mode bit misread");
    fixed_bits_a: assert property (rdCtrl |=> busRdata[4:3] == 2'b11) else $error("fixed bits not one");
    pin_chip_reset_enable_a: assert property (wdOvf && chip_reset_enable_r |-> ##132 !overflowOutN ##1 overflowOutN)
        else $error("overflow pin length wrong with reset");
    pin_norst_a: assert property (wdOvf && !chip_reset_enable_r |=> !chipResetOut [*2] ##128 !overflowOutN ##1 overflowOutN)
        else $error("overflow pin length wrong without reset");
    chip_reset_a: assert property (wdOvf && chip_reset_enable_r |=> chipResetOut ##[517:517] chipResetOut ##1 !chipResetOut)
        else $error("chip reset length wrong");
    pin_cause_a: assert property ($fell(overflowOutN) |-> $past(wdOvf)) else $error("pin low without watchdog overflow");
    irq_set_a: assert property (itOvf |=> flag_r && intervalIrq && count_r == 8'h00) else $error("interval wrap missed");
    flag_keep_a: assert property (flag_r && !flagArm_r && !wdOvf |=> flag_r) else $error("flag cleared without read");
    flag_clear_a: assert property (wrCtrl && flagArm_r && !busWdata[7] && !itOvf && !wdOvf |=> !flag_r)
        else $error("armed clear of flag missed");
    tick_gate_a: assert property (!en_r |=> !tickBus.tick) else $error("tick while disabled");
    chip_cause_a: assert property ($rose(chipResetOut) |-> $past(wdOvf && chip_reset_enable_r))
        else $error("chip reset without enabled overflow");
    en_start_a: assert property (wrCtrl && busWdata[5] && !wdOvf |=> en_r) else $error("enable write lost");
    auto_clear_a: assert property (wdOvf |=> !flag_r && !en_r) else $error("internal reset left state");
    byte_ignore_a: assert property (busWrite && !busWord && !wdOvf |=> $stable({mode_r, en_r, cks_r}))
        else $error("byte write changed control");
    key_guard_a: assert property (busWrite && busAddr == wit_pkg::ADDR_CNTCTRL_WR && busWdata[15:8] != wit_pkg::KEY_CTRL
        && !wdOvf |=> $stable({mode_r, en_r, cks_r})) else $error("unkeyed write changed control");

    interval_wrap_c: cover property (itOvf);
    dog_reset_c: cover property (wdOvf && chip_reset_enable_r);
    dog_noreset_c: cover property (wdOvf && !chip_reset_enable_r);
    flag_clear_c: cover property (wrCtrl && flagArm_r && !busWdata[7]);
    // Overflow with the flag still up from interval use
    stale_flag_c: cover property (wdOvf && flag_r);
endmodule

// ==== wit_cpu_model.sv ====
`timescale 1ns/1ps
// Software side of the register bus: keyed word writes and plain reads
module wit_cpu_model (
    input wire logic clk,
    output logic [15:0] busAddr,
    output logic busRead,
    output logic busWrite,
    output logic busWord,
    output logic [15:0] busWdata,
    input wire logic [7:0] busRdata
);
    // Idle bus at time zero
    initial begin
        busAddr = 16'h0000;
        busRead = 1'b0;
        busWrite = 1'b0;
        busWord = 1'b1;
        busWdata = 16'h0000;
    end
    // Strobes drop and address/data are inverted so stale values never look valid
    task automatic release_bus();
        busRead <= 1'b0;
        busWrite <= 1'b0;
        busAddr <= ~busAddr;
        busWdata <= ~busWdata;
    endtask
    // Keyed write; word low gives a byte write that must be ignored
    task automatic wr(input logic [15:0] a, input logic [7:0] key, input logic [7:0] v, input logic w = 1'b1);
        @(posedge clk);
        busAddr <= a;
        busWdata <= {key, v};
        busWord <= w;
        busWrite <= 1'b1;
        @(posedge clk);
        release_bus();
    endtask
    // Read data stands one cycle after the read edge
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        busAddr <= a;
        busRead <= 1'b1;
        @(posedge clk);
        release_bus();
        #1 d = busRdata;
    endtask
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
    logic clk;
    logic resetn;
    logic [15:0] busAddr;
    logic busRead;
    logic busWrite;
    logic busWord;
    logic [15:0] busWdata;
    logic [7:0] busRdata;
    logic overflowOutN;
    logic intervalIrq;
    logic chipResetOut;
    logic [7:0] d;
    logic [7:0] v;
    integer fails = 0;
    integer samples_checked = 0;
    integer seed = 49315;
    int n;
    int lowN;
    int hiR;
    int dv;
    localparam logic [15:0] AW = wit_pkg::ADDR_CNTCTRL_WR;
    localparam logic [15:0] AR = wit_pkg::ADDR_RSTCTRL_WR;
    localparam logic [15:0] RC = wit_pkg::ADDR_CTRL_RD;
    localparam logic [15:0] RN = wit_pkg::ADDR_COUNT_RD;
    localparam logic [15:0] RR = wit_pkg::ADDR_RSTCTRL_RD;
    wit_guard_timer u_dut (.clk(clk), .resetn(resetn), .busAddr(busAddr), .busRead(busRead),
        .busWrite(busWrite), .busWord(busWord), .busWdata(busWdata), .busRdata(busRdata),
        .overflowOutN(overflowOutN), .intervalIrq(intervalIrq), .chipResetOut(chipResetOut));
    wit_cpu_model u_cpu (.clk(clk), .busAddr(busAddr), .busRead(busRead), .busWrite(busWrite),
        .busWord(busWord), .busWdata(busWdata), .busRdata(busRdata));
    // 100 ns clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic close_out();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
        u_cpu.rd(a, d);
        chk({8'h00, d}, {8'h00, e});
    endtask
    // Expected control byte: bits 4 and 3 always read high
    function automatic logic [7:0] ctl(input logic f, input logic m, input logic e, input logic [2:0] c);
        return {f, m, e, 2'b11, c};
    endfunction
    // Divide ratio per clock select code
    function automatic int divf(input int c);
        int t[8] = '{2, 64, 128, 512, 2048, 8192, 32768, 131072};
        return t[c];
    endfunction
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    // Bounded wait for the interval request
    task automatic wait_irq(input int lim, output int cyc);
        cyc = 0;
        while (intervalIrq !== 1'b1) begin
            if (cyc >= lim) begin
                fails++;
                close_out();
            end
            step();
            cyc++;
        end
    endtask
    initial begin
        resetn = 1'b0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        rdchk(RC, 8'h18);
        rdchk(RN, 8'h00);
        rdchk(RR, 8'h1F);
        rdchk(16'hFFB0, 8'h00);
        chk(overflowOutN, 1'b1);
        // Byte write and wrong key both refused
        u_cpu.wr(AW, wit_pkg::KEY_CTRL, 8'h27, 1'b0);
        u_cpu.wr(AW, 8'h33, 8'h27);
        rdchk(RC, 8'h18);
        // Slowest tap keeps the count still for random write/readback
        u_cpu.wr(AW, wit_pkg::KEY_CTRL, 8'h27);
        rdchk(RC, ctl(0, 0, 1, 7));
        repeat (8) begin
            v = 8'($random(seed));
            u_cpu.wr(AW, wit_pkg::KEY_COUNT, v);
            rdchk(RN, v);
        end
        u_cpu.wr(AW, wit_pkg::KEY_CTRL, 8'h07);
        rdchk(RN, 8'h00);
        $display("test access done");
        // Taps 0 to 6 timed from a preset count of FF to the wrap
        for (int c = 0; c < 7; c++) begin
            dv = divf(c);
            u_cpu.wr(AW, wit_pkg::KEY_CTRL, ctl(0, 0, 1, 3'(c)));
            u_cpu.wr(AW, wit_pkg::KEY_COUNT, 8'hFF);
            wait_irq(dv + 8, n);
            chk(16'(n >= dv - 6 && n <= dv + 4), 16'h0001);
            chk(overflowOutN, 1'b1);
            rdchk(RC, ctl(1, 0, 1, 3'(c)));
            u_cpu.wr(AW, wit_pkg::KEY_CTRL, 8'h80);
            u_cpu.wr(AW, wit_pkg::KEY_CTRL, 8'h00);
            rdchk(RC, 8'h98);
            u_cpu.wr(AW, wit_pkg::KEY_CTRL, 8'h00);
            rdchk(RC, 8'h18);
            chk(intervalIrq, 1'b0);
        end
        $display("test interval done");
        // Watchdog overflow with and without chip reset
        for (int r = 0; r < 2; r++) begin
            u_cpu.wr(AR, wit_pkg::KEY_CHIP_RESET_ENABLE, {1'b0, 1'(r), 6'h00});
            u_cpu.wr(AW, wit_pkg::KEY_CTRL, ctl(0, 0, 1, 0));
            u_cpu.wr(AW, wit_pkg::KEY_COUNT, 8'hFF);
            wait_irq(20, n);
            u_cpu.wr(AW, wit_pkg::KEY_CTRL, ctl(0, 1, 1, 0));
            u_cpu.wr(AW, wit_pkg::KEY_COUNT, 8'hFF);
            n = 0;
            while (overflowOutN !== 1'b0) begin
                if (n >= 20) begin
                    fails++;
                    close_out();
                end
                step();
                n++;
            end
            lowN = 0;
            hiR = 0;
            repeat (600) begin
                lowN += int'(overflowOutN === 1'b0);
                hiR += int'(chipResetOut === 1'b1);
                step();
            end
            chk(16'(lowN), 16'(r ? 132 : 130));
            chk(16'(hiR), 16'(r ? 518 : 0));
            rdchk(RC, 8'h18);
            chk(intervalIrq, 1'b0);
            rdchk(RR, {1'b1, 1'(r), 6'h1F});
            u_cpu.wr(AR, wit_pkg::KEY_WOVF, 8'h00);
            rdchk(RR, {1'b0, 1'(r), 6'h1F});
        end
        $display("test watchdog done");
        // Mid-run reset clears the reset control register as well
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rdchk(RR, 8'h1F);
        rdchk(RC, 8'h18);
        $display("test reset done");
        close_out();
    end
endmodule
